/* File: hw/chpwr_pkg.sv */
// Package: register map, field positions and reset values for channel power
package chpwr_pkg;
  localparam logic [7:0] CHPWR_ADDR_IN_EN = 8'h73;
  localparam logic [7:0] CHPWR_ADDR_OUT_EN = 8'h74;
  localparam logic [7:0] CHPWR_ADDR_PWR = 8'h75;
  localparam logic [7:0] CHPWR_ADDR_STS = 8'h76;
  localparam logic [7:0] CHPWR_RST_IN_EN = 8'hF0;
  localparam logic [7:0] CHPWR_RST_OUT_EN = 8'h00;
  localparam logic [7:0] CHPWR_RST_PWR = 8'h00;
  localparam logic [7:0] CHPWR_RST_STS = 8'h00;
  localparam logic [7:0] CHPWR_PWR_WMASK = 8'hFE;
  localparam int CHPWR_BIT_BIAS = 7;
  localparam int CHPWR_BIT_MIC = 6;
  localparam int CHPWR_BIT_PLL = 5;
  localparam int CHPWR_BIT_DYN = 4;
  localparam int CHPWR_BIT_RNG_HI = 3;
  localparam int CHPWR_BIT_RNG_LO = 2;
  localparam int CHPWR_NCH = 8;
endpackage

/* File: hw/chpwr_chan.sv */
// One channel's power state holder
`timescale 1ns/1ns
module chpwr_chan
  import chpwr_pkg::*;
(
  // Clock and control
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Decision inputs
  input wire logic want_on,
  input wire logic may_change,
  // State
  output logic powered_r
);
  logic powered_nxt;

  // Follow the request only when a change is allowed
  always_comb
  begin
    powered_nxt = powered_r;
    if (may_change)
    begin
      powered_nxt = want_on;
    end
  end

  // Register the state
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      powered_r <= 1'b0;
    end
    else if (clk_en)
    begin
      powered_r <= powered_nxt;
    end
  end
endmodule // chpwr_chan

/* File: hw/chpwr_top.sv */
// Channel power configuration register bank
`timescale 1ns/1ns
module chpwr_top
  import chpwr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port from the control interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  // Power and enable outputs
  output logic [7:0] input_channel_enable_r,
  output logic [7:0] output_slot_enable_r,
  output logic mic_bias_power_on_r,
  output logic pll_power_on_r,
  output logic [7:0] channel_power_status_r
);
  logic [7:0] in_en_nxt;
  logic [7:0] out_en_nxt;
  logic [7:0] pwr_r;
  logic [7:0] pwr_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] want_on;
  logic [7:0] dyn_ok;
  logic [7:0] may_change;
  logic recording;
  logic [7:0] ch_on;

  // Eight channels fill the eight-bit registers exactly
  if (CHPWR_NCH != 8)
  begin : g_bad_nch
    $error("channel count must equal the register width");
  end

  // Register writes
  always_comb
  begin
    in_en_nxt = input_channel_enable_r;
    out_en_nxt = output_slot_enable_r;
    pwr_nxt = pwr_r;
    if (reg_wr)
    begin
      case (reg_addr)
        CHPWR_ADDR_IN_EN: in_en_nxt = reg_wdata;
        CHPWR_ADDR_OUT_EN: out_en_nxt = reg_wdata;
        CHPWR_ADDR_PWR: pwr_nxt = reg_wdata & CHPWR_PWR_WMASK;
        default: pwr_nxt = pwr_r;
      endcase
    end
  end

  // Read mux, status register ignores writes
  always_comb
  begin
    case (reg_addr)
      CHPWR_ADDR_IN_EN: rdata_nxt = input_channel_enable_r;
      CHPWR_ADDR_OUT_EN: rdata_nxt = output_slot_enable_r;
      CHPWR_ADDR_PWR: rdata_nxt = pwr_r;
      CHPWR_ADDR_STS: rdata_nxt = channel_power_status_r;
      default: rdata_nxt = 8'h00;
    endcase
    if (!reg_rd)
    begin
      rdata_nxt = reg_rdata_r;
    end
  end

  // A status read returns the status seen at the read edge
  a_rd_status: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == CHPWR_ADDR_STS
    |=> reg_rdata_r == $past(channel_power_status_r))
    else $error("status read returned a stale value");

  // Register storage
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      input_channel_enable_r <= CHPWR_RST_IN_EN;
      output_slot_enable_r <= CHPWR_RST_OUT_EN;
      pwr_r <= CHPWR_RST_PWR;
      reg_rdata_r <= 8'h00;
      mic_bias_power_on_r <= 1'b0;
      pll_power_on_r <= 1'b0;
    end
    else if (clk_en)
    begin
      input_channel_enable_r <= in_en_nxt;
      output_slot_enable_r <= out_en_nxt;
      pwr_r <= pwr_nxt;
      reg_rdata_r <= rdata_nxt;
      mic_bias_power_on_r <= pwr_nxt[CHPWR_BIT_BIAS];
      pll_power_on_r <= pwr_nxt[CHPWR_BIT_PLL];
    end
  end

  // A power write keeps every bit but the read-only one
  a_pwr_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == CHPWR_ADDR_PWR
    |=> pwr_r == ($past(reg_wdata) & 8'hFE))
    else $error("power write stored wrongly");
  // Leaving reset shows every register at its reset value
  a_rst_values: assert property (
    @(posedge clock)
    $rose(rst_n) |-> input_channel_enable_r == 8'hF0
    && output_slot_enable_r == 8'h00 && pwr_r == 8'h00
    && channel_power_status_r == 8'h00 && reg_rdata_r == 8'h00)
    else $error("register not at reset value");
  // Clock enable low holds the power and enable registers and channel state
  a_enable_freezes: assert property (
    @(posedge clock) disable iff (!rst_n)
    !clk_en |=> pwr_r == $past(pwr_r) && ch_on == $past(ch_on)
    && input_channel_enable_r == $past(input_channel_enable_r)
    && output_slot_enable_r == $past(output_slot_enable_r))
    else $error("state moved while clock enable was low");

  // Channels covered by the dynamic range field, channel 1 at bit 7
  always_comb
  begin
    case (pwr_r[CHPWR_BIT_RNG_HI:CHPWR_BIT_RNG_LO])
      2'h0: dyn_ok = 8'hC0;
      2'h1: dyn_ok = 8'hF0;
      2'h2: dyn_ok = 8'hFC;
      2'h3: dyn_ok = 8'hFF;
      default: dyn_ok = 8'h00;
    endcase
  end

  // Global power gates each enabled channel
  assign want_on = pwr_r[CHPWR_BIT_MIC] ? input_channel_enable_r
                                        : 8'h00;
  assign recording = |channel_power_status_r;
  // Global switch always acts; per-channel changes need idle or dynamic mode
  always_comb
  begin
    for (int i = 0; i < CHPWR_NCH; i++)
    begin
      may_change[i] = !pwr_r[CHPWR_BIT_MIC] || !recording
                   || (pwr_r[CHPWR_BIT_DYN] && dyn_ok[i]);
    end
  end

  // In dynamic mode while recording only channels inside the range may change
  a_dyn_range: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && pwr_r[CHPWR_BIT_MIC] && pwr_r[CHPWR_BIT_DYN] && recording
    |=> ((ch_on ^ $past(ch_on)) & ~(8'hFF << (2 * (3
    - $past(pwr_r[CHPWR_BIT_RNG_HI:CHPWR_BIT_RNG_LO]))))) == 8'h00)
    else $error("channel outside the dynamic range changed");

  // Per-channel power state holders
  for (genvar g = 0; g < CHPWR_NCH; g++)
  begin : g_ch
    chpwr_chan u_ch (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .want_on(want_on[g]),
      .may_change(may_change[g]),
      .powered_r(ch_on[g])
    );
  end

  // Status register mirrors channel power states
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      channel_power_status_r <= CHPWR_RST_STS;
    end
    else if (clk_en)
    begin
      channel_power_status_r <= ch_on;
    end
  end

  // Checks
  // A channel may only rise with global power on and its enable set
  a_rise_needs_power: assert property (
    @(posedge clock) disable iff (!rst_n)
    ((ch_on & ~$past(ch_on)) & ~($past(input_channel_enable_r)
    & {8{$past(pwr_r[CHPWR_BIT_MIC])}})) == 8'h00)
    else $error("channel rose without global power");
  // Status follows the channel state holders one cycle later
  a_sts_mirror: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en |=> channel_power_status_r == $past(ch_on))
    else $error("status does not mirror channel state");
  // Global power off clears every status bit two enabled cycles on
  a_off_clears: assert property (
    @(posedge clock) disable iff (!rst_n)
    (clk_en && !pwr_r[CHPWR_BIT_MIC]) ##1 clk_en[*2] |-> ##0
    channel_power_status_r == 8'h00)
    else $error("status not cleared after power off");
  // Reserved read-only bit never holds a one
  a_res0_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    pwr_r[0] == 1'b0)
    else $error("reserved bit zero set");
  // A power write sets the PLL switch from the written bit
  a_pll_follow: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == CHPWR_ADDR_PWR
    |=> pll_power_on_r == $past(reg_wdata[CHPWR_BIT_PLL]))
    else $error("pll power out of step");
  // A power write sets the bias switch from the written bit
  a_bias_follow: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == CHPWR_ADDR_PWR
    |=> mic_bias_power_on_r == $past(reg_wdata[CHPWR_BIT_BIAS]))
    else $error("bias power out of step");
  // Fixed mode freezes every channel while any of them records
  a_hold_static: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && pwr_r[CHPWR_BIT_MIC] && !pwr_r[CHPWR_BIT_DYN] && recording
    |=> ch_on == $past(ch_on))
    else $error("channel changed while recording");
  // Enable register writes land one cycle later
  a_out_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == CHPWR_ADDR_OUT_EN
    |=> output_slot_enable_r == $past(reg_wdata))
    else $error("output slot write lost");
  a_in_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == CHPWR_ADDR_IN_EN
    |=> input_channel_enable_r == $past(reg_wdata))
    else $error("input enable write lost");
endmodule // chpwr_top

/* File: tb/chpwr_host.sv */
// Host model that issues register strobes
`timescale 1ns/1ns
module chpwr_host
(
  // Clock
  input wire logic clock,
  // Register strobes
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // Idle bus at time zero
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
  end
  // One strobe held across one rising edge, then released
  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clock);
    {reg_wr, reg_rd} = 2'b00;
    reg_wdata = ~d; // Stale data never lingers
  endtask
endmodule // chpwr_host

/* File: tb/testbench.sv */
// Self-checking bench for the channel power register bank
`timescale 1ns/1ns
module testbench;
  logic clock, rst_n, clk_en, reg_wr, reg_rd, bias, pll, rd_d;
  logic [7:0] reg_addr, reg_wdata, rdata, in_en, out_en, sts, r;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  chpwr_host u_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  chpwr_top u_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(rdata),
    .input_channel_enable_r(in_en), .output_slot_enable_r(out_en),
    .mic_bias_power_on_r(bias), .pll_power_on_r(pll),
    .channel_power_status_r(sts));
  // 25 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Read with its expected value noted first
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.cyc(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input int w);
    u_host.cyc(1'b1, a, d);
    repeat (w) @(negedge clock);
  endtask
  task automatic stop_test();
    if (exp_q.size() != 0)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: reads left unanswered", $time);
    end
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Note read edges, count cycles, cut a hang short
  always @(posedge clock)
  begin
    rd_d <= reg_rd && clk_en;
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_fail++;
      stop_test();
    end
  end
  // Read data is settled by the falling edge after the read edge
  always @(negedge clock)
    if (rd_d === 1'b1 && exp_q.size() > 0)
      chk(exp_q.pop_front(), rdata);
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    r = 8'($urandom(32'h25FC));
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    // Reset values and an unmapped read
    rd(8'h73, 8'hF0);
    rd(8'h74, 8'h00);
    rd(8'h75, 8'h00);
    rd(8'h76, 8'h00);
    rd(8'h10, 8'h00);
    $display("reset test done");
    // Slot and input enables, then global channel power
    wr(8'h74, r, 0);
    chk(r, out_en);
    // Clock enable low drops a write
    clk_en = 1'b0;
    wr(8'h74, ~r, 1);
    chk(r, out_en);
    clk_en = 1'b1;
    r = 8'($urandom) | 8'h80;
    wr(8'h73, r, 0);
    chk(r, in_en);
    wr(8'h75, 8'h40, 3);
    rd(8'h76, r);
    $display("power test done");
    // Fixed mode freezes channels while recording
    wr(8'h73, 8'h80, 3);
    rd(8'h76, r);
    // Dynamic mode, channel 1 always kept on
    wr(8'h75, 8'h5C, 0);
    wr(8'h73, 8'hC0, 3);
    rd(8'h76, 8'hC0);
    // Range of channels 1-2 leaves channels 3-4 frozen
    wr(8'h75, 8'h50, 0);
    wr(8'h73, 8'hF0, 3);
    rd(8'h76, 8'hC0);
    // Range of channels 1-6, then 1-4
    wr(8'h75, 8'h58, 0);
    wr(8'h73, 8'hBC, 3);
    rd(8'h76, 8'hBC);
    wr(8'h75, 8'h54, 0);
    wr(8'h73, 8'hF0, 3);
    rd(8'h76, 8'hFC);
    $display("dynamic test done");
    // Reserved bit, bias and PLL, status write ignored
    wr(8'h75, 8'hFF, 0);
    chk(8'h03, {6'h00, bias, pll});
    wr(8'h76, 8'h00, 3);
    rd(8'h76, 8'hF0);
    rd(8'h75, 8'hFE);
    wr(8'h75, 8'h00, 3);
    chk(8'h00, {6'h00, bias, pll});
    rd(8'h76, 8'h00);
    $display("reserved test done");
    // Reset in mid-run restores the enable and status registers
    wr(8'h73, 8'h0F, 0);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    rd(8'h73, 8'hF0);
    rd(8'h74, 8'h00);
    rd(8'h76, 8'h00);
    $display("reset again test done");
    @(posedge clock);
    stop_test();
  end
endmodule // testbench
